// *** src/sram_ddr_consts.svh ***
// constants for the burst-of-two double-data-rate common-io sram core
`ifndef SRAM_DDR_CONSTS_SVH
`define SRAM_DDR_CONSTS_SVH
`define DQ_W 36
`define LANE_W 9
`define LANES 4
`define NARROW_LANES 2
`define ADDR_W 4
`define IDX_W 5
`define WBUF_DEPTH 4
`define WBUF_KEEP 3
`define PIPE_LEN 6
`define WR_BEAT0_STAGE 2
`define WR_BEAT1_STAGE 3
`define RD_BEAT0_STAGE 5
`define RD_BEAT1_STAGE 6
`define SYNC_W 48
`endif

// *** src/sram_ddr_pkg.sv ***
// types shared by the sram core, its checker, the controller model and the bench
`include "sram_ddr_consts.svh"
package sram_ddr_pkg;
  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`IDX_W-1:0] idx_t;
  typedef logic [`DQ_W-1:0] data_t;
  typedef logic [`LANES-1:0] lanes_t;
  typedef enum logic {k_rise_slot, kn_rise_slot} slot_t;
endpackage : sram_ddr_pkg

// *** src/sram_ddr_core.sv ***
// burst-of-two ddr common-io sram: command decode, beat timing, write buffer
`timescale 1ns/1ps
`include "sram_ddr_consts.svh"

module sram_wbuf #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int PW = $clog2(D);
  logic [W-1:0] store [D];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0] next_count;
  logic push;
  logic pop;

  always_comb begin
    in_ready_o = (count != (PW+1)'(D));
    out_valid_o = (count != '0);
    out_data_o = store[rd_ptr];
    level_o = count;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce_i) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage is data only, so it takes no reset
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      store[wr_ptr] <= in_data_i;
    end
  end
endmodule : sram_wbuf

module sram_ddr_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cfg_x18_i,
  input wire logic new_address_strobe_n_i,
  input wire logic read_not_write_i,
  input wire sram_ddr_pkg::addr_t burst_start_address_i,
  input wire sram_ddr_pkg::lanes_t byte_write_enable_n_i,
  input wire sram_ddr_pkg::data_t dq_i,
  output sram_ddr_pkg::data_t dq_o,
  output logic dq_oe_o,
  output logic wbuf_drop_o
);
  import sram_ddr_pkg::*;

  localparam int EW = `IDX_W + `DQ_W + `LANES;

  // pins cross in through two flops; first stage feeds only the second
  logic [`SYNC_W-1:0] sync1;
  logic [`SYNC_W-1:0] sync2;
  logic x18_s;
  logic ldn_s;
  logic rw_s;
  addr_t addr_s;
  lanes_t bwn_s;
  data_t dq_s;

  slot_t slot;
  slot_t next_slot;
  logic [`PIPE_LEN:1] p_v;
  logic [`PIPE_LEN:1] p_rd;
  addr_t p_a [`PIPE_LEN:1];
  logic [`PIPE_LEN:1] next_p_v;
  logic [`PIPE_LEN:1] next_p_rd;
  addr_t next_p_a [`PIPE_LEN:1];

  idx_t hist_idx [2];
  data_t hist_data [2];
  lanes_t hist_en [2];
  logic [1:0] hist_v;
  idx_t next_hist_idx [2];
  data_t next_hist_data [2];
  lanes_t next_hist_en [2];
  logic [1:0] next_hist_v;

  data_t next_dq;
  logic next_oe;
  logic next_drop;

  data_t mem [2**`IDX_W];

  logic cmd_v;
  logic wbeat;
  idx_t w_idx;
  lanes_t w_en;
  logic push;
  logic rbeat;
  idx_t r_idx;
  data_t r_data;

  logic in_ready;
  logic out_valid;
  logic out_ready;
  logic [EW-1:0] out_data;
  logic [$clog2(`WBUF_DEPTH):0] level;
  idx_t c_idx;
  data_t c_data;
  lanes_t c_en;

  assign x18_s = sync2[47];
  assign ldn_s = sync2[46];
  assign rw_s = sync2[45];
  assign addr_s = sync2[44:41];
  assign bwn_s = sync2[39:36];
  assign dq_s = sync2[35:0];
  assign {c_idx, c_data, c_en} = out_data;

  always_comb begin
    // commands are only looked at on the primary-clock slot
    cmd_v = (slot == k_rise_slot) && !ldn_s;
    next_slot = (slot == k_rise_slot) ? kn_rise_slot : k_rise_slot;
    next_p_v[1] = cmd_v;
    next_p_rd[1] = rw_s;
    next_p_a[1] = addr_s;
    for (int i = 2; i <= `PIPE_LEN; i++) begin
      next_p_v[i] = p_v[i-1];
      next_p_rd[i] = p_rd[i-1];
      next_p_a[i] = p_a[i-1];
    end

    // write beats: first on the primary rise a cycle on, then the next half
    w_idx = '0;
    wbeat = 1'b0;
    if (p_v[`WR_BEAT0_STAGE] && !p_rd[`WR_BEAT0_STAGE]) begin
      wbeat = 1'b1;
      w_idx = {p_a[`WR_BEAT0_STAGE], 1'b0};
    end else if (p_v[`WR_BEAT1_STAGE] && !p_rd[`WR_BEAT1_STAGE]) begin
      wbeat = 1'b1;
      w_idx = {p_a[`WR_BEAT1_STAGE], 1'b1};
    end
    // narrow mode has only the two low lanes
    for (int l = 0; l < `LANES; l++) begin
      w_en[l] = !bwn_s[l] && (l < `NARROW_LANES || !x18_s);
    end
    push = wbeat && (w_en != '0);

    next_hist_idx = hist_idx;
    next_hist_data = hist_data;
    next_hist_en = hist_en;
    next_hist_v = hist_v;
    if (push && in_ready) begin
      next_hist_idx[1] = hist_idx[0];
      next_hist_data[1] = hist_data[0];
      next_hist_en[1] = hist_en[0];
      next_hist_v[1] = hist_v[0];
      next_hist_idx[0] = w_idx;
      next_hist_data[0] = dq_s;
      next_hist_en[0] = w_en;
      next_hist_v[0] = 1'b1;
    end
    // a full buffer loses the beat; the flag tells the controller
    next_drop = push && !in_ready;

    // read beats load five and six slots after decode: t+2.5 and t+3.0
    r_idx = '0;
    rbeat = 1'b0;
    if (p_v[`RD_BEAT0_STAGE] && p_rd[`RD_BEAT0_STAGE]) begin
      rbeat = 1'b1;
      r_idx = {p_a[`RD_BEAT0_STAGE], 1'b0};
    end else if (p_v[`RD_BEAT1_STAGE] && p_rd[`RD_BEAT1_STAGE]) begin
      rbeat = 1'b1;
      r_idx = {p_a[`RD_BEAT1_STAGE], 1'b1};
    end
    // older buffered beat first, newer one last, lane by lane
    r_data = mem[r_idx];
    for (int h = 1; h >= 0; h--) begin
      for (int l = 0; l < `LANES; l++) begin
        if (hist_v[h] && hist_idx[h] == r_idx && hist_en[h][l]) begin
          r_data[l*`LANE_W +: `LANE_W] = hist_data[h][l*`LANE_W +: `LANE_W];
        end
      end
    end
    next_dq = rbeat ? r_data : dq_o;
    next_oe = rbeat;
    // the last two beats stay buffered; commit starts with the third
    out_ready = level >= ($clog2(`WBUF_DEPTH)+1)'(`WBUF_KEEP);
  end

  sram_wbuf #(
    .W(EW),
    .D(`WBUF_DEPTH)
  ) u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(push),
    .in_ready_o(in_ready),
    .in_data_i({w_idx, dq_s, w_en}),
    .out_valid_o(out_valid),
    .out_ready_i(out_ready),
    .out_data_o(out_data),
    .level_o(level)
  );

  // ce low is a stopped clock: everything, the bus included, holds
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= '1;
      sync2 <= '1;
      slot <= k_rise_slot;
    end else if (ce_i) begin
      sync1 <= {cfg_x18_i, new_address_strobe_n_i, read_not_write_i,
                burst_start_address_i, 1'b0, byte_write_enable_n_i, dq_i};
      sync2 <= sync1;
      slot <= next_slot;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_v <= '0;
      p_rd <= '0;
      p_a <= '{default: '0};
    end else if (ce_i) begin
      p_v <= next_p_v;
      p_rd <= next_p_rd;
      p_a <= next_p_a;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hist_idx <= '{default: '0};
      hist_data <= '{default: '0};
      hist_en <= '{default: '0};
      hist_v <= '0;
    end else if (ce_i) begin
      hist_idx <= next_hist_idx;
      hist_data <= next_hist_data;
      hist_en <= next_hist_en;
      hist_v <= next_hist_v;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dq_o <= '0;
      dq_oe_o <= 1'b0;
      wbuf_drop_o <= 1'b0;
    end else if (ce_i) begin
      dq_o <= next_dq;
      dq_oe_o <= next_oe;
      wbuf_drop_o <= next_drop;
    end
  end

  // array commit, lane by lane, from the buffer's head
  always_ff @(posedge clk_i) begin
    if (ce_i && out_valid && out_ready) begin
      for (int l = 0; l < `LANES; l++) begin
        if (c_en[l]) begin
          mem[c_idx][l*`LANE_W +: `LANE_W] <= c_data[l*`LANE_W +: `LANE_W];
        end
      end
    end
  end
endmodule : sram_ddr_core

// *** tb/sram_ddr_chk.sv ***
// assertions on the ddr sram core ports
`timescale 1ns/1ps
module sram_ddr_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic new_address_strobe_n_i,
  input wire logic read_not_write_i,
  input wire sram_ddr_pkg::data_t dq_o,
  input wire logic dq_oe_o
);
  import sram_ddr_pkg::*;
  logic odd;
  logic off;
  logic cmd;
  logic rd;
  // slot parity; odd slots never take a command
  always_ff @(posedge clk_i) odd <= rst_i ? 1'b0 : odd ^ ce_i;
  assign off = rst_i || !ce_i;
  assign cmd = !odd && !new_address_strobe_n_i;
  assign rd = cmd && read_not_write_i;
  default clocking cb @(posedge clk_i);
  endclocking
  a_read_beats: assert property (disable iff (off)
    rd |-> ##8 dq_oe_o ##1 dq_oe_o) else $error("read beats missing");
  a_drive_cause: assert property (disable iff (off)
    dq_oe_o |-> $past(rd, 8) || $past(rd, 9)) else $error("stray drive");
  a_rose_cause: assert property (disable iff (off)
    $rose(dq_oe_o) |-> $past(rd, 8)) else $error("drive off slot");
  a_write_quiet: assert property (disable iff (off)
    cmd && !read_not_write_i |-> ##8 !dq_oe_o[*2]) else $error("write drove");
  a_nop_quiet: assert property (disable iff (off)
    !odd && new_address_strobe_n_i |-> ##8 !dq_oe_o[*2]) else $error("nop");
  a_burst_pair: assert property (disable iff (off)
    $fell(dq_oe_o) |-> $past(dq_oe_o, 2)) else $error("short burst");
  a_freeze_hold: assert property (disable iff (rst_i)
    !ce_i |=> $stable(dq_o) && $stable(dq_oe_o)) else $error("moved");
  a_reset_quiet: assert property (
    rst_i |=> !dq_oe_o && dq_o == '0) else $error("drive in reset");
endmodule : sram_ddr_chk
bind sram_ddr_core sram_ddr_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .new_address_strobe_n_i(new_address_strobe_n_i),
  .read_not_write_i(read_not_write_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// *** tb/sram_ctrl_model.sv ***
// controller model: commands on primary slots, late write beats
`timescale 1ns/1ps
module sram_ctrl_model (
  input wire logic clk_i,
  output logic strobe_n_o,
  output logic rw_o,
  output sram_ddr_pkg::addr_t addr_o,
  output sram_ddr_pkg::lanes_t bwn_o,
  output sram_ddr_pkg::data_t wd_o
);
  import sram_ddr_pkg::*;
  int seq = 0;
  initial {strobe_n_o, rw_o, addr_o, bwn_o, wd_o} = '1;
  // enter at a falling edge before a primary slot; takes two slots
  task automatic cmd(logic rd, addr_t a, lanes_t b0, lanes_t b1,
      data_t d0, data_t d1);
    int id;
    strobe_n_o = 1'b0;
    rw_o = rd;
    addr_o = a;
    if (!rd) begin
      seq++;
      id = seq;
      fork
        begin
          repeat (2) @(negedge clk_i);
          bwn_o = b0;
          wd_o = d0;
          @(negedge clk_i);
          bwn_o = b1;
          wd_o = d1;
          @(negedge clk_i);
          // release the lines only if no newer write owns them by now
          if (id == seq) begin
            bwn_o = '1;
            wd_o = ~d1;
          end
        end
      join_none
    end
    @(negedge clk_i);
    strobe_n_o = 1'b1;
    addr_o = ~a;
    @(negedge clk_i);
  endtask : cmd
endmodule : sram_ctrl_model

// *** tb/ddr_burst2_cio_sram_command_timing_tb.sv ***
// bench: controller model drives the core; a shadow array judges reads
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module ddr_burst2_cio_sram_command_timing_tb;
  import sram_ddr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic cfg_x18_i = 1'b0;
  logic strobe_n, rw, oe;
  logic drop;
  addr_t addr;
  lanes_t bwn;
  data_t wd, dq, v;
  data_t mem [32];
  int bad_count = 0;
  int tests_run = 0;
  int drops = 0;
  always #12.5 clk_i = ~clk_i;
  // a lost write beat is a pulse, so it is counted as it happens
  always @(posedge clk_i) if (!rst_i && drop !== 1'b0) drops++;
  sram_ctrl_model ctl_u (.clk_i(clk_i), .strobe_n_o(strobe_n), .rw_o(rw),
    .addr_o(addr), .bwn_o(bwn), .wd_o(wd));
  sram_ddr_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cfg_x18_i(cfg_x18_i), .new_address_strobe_n_i(strobe_n),
    .read_not_write_i(rw), .burst_start_address_i(addr),
    .byte_write_enable_n_i(bwn), .dq_i(wd), .dq_o(dq), .dq_oe_o(oe),
    .wbuf_drop_o(drop));
  // shadow keeps enabled lanes only; narrow mode never writes lanes 2, 3
  task automatic wr(addr_t a, lanes_t b0, lanes_t b1, data_t d0, data_t d1);
    lanes_t b [2];
    data_t d [2];
    b = '{b0, b1};
    d = '{d0, d1};
    for (int i = 0; i < 2; i++)
      for (int l = 0; l < 4; l++)
        if (!b[i][l] && !(cfg_x18_i && l > 1))
          mem[{a, i[0]}][9*l +: 9] = d[i][9*l +: 9];
    ctl_u.cmd(1'b0, a, b0, b1, d0, d1);
  endtask : wr
  task automatic rd(addr_t a);
    ctl_u.cmd(1'b1, a, '1, '1, '0, '0);
    repeat (6) @(negedge clk_i);
    `CHK("drive", 1'b1, oe)
    `CHK("beat0", mem[{a, 1'b0}], dq)
    @(negedge clk_i);
    `CHK("beat1", mem[{a, 1'b1}], dq)
    @(negedge clk_i);
    `CHK("release", 1'b0, oe)
  endtask : rd
  task automatic t_lanes;
    wr(4'h3, '0, '0, 36'h123456789, 36'hfedcba987);
    rd(4'h3);
    wr(4'h5, '0, '0, '0, '1);
    for (int l = 0; l < 4; l++)
      wr(4'h5, ~(4'h1 << l), ~(4'h8 >> l), {4{9'(l + 1)}}, {4{9'(l + 5)}});
    wr(4'h5, '1, '1, '1, '0);
    rd(4'h5);
    rd(4'h3);
  endtask : t_lanes
  task automatic t_narrow;
    wr(4'h6, '0, '0, '0, '0);
    repeat (4) @(negedge clk_i);
    cfg_x18_i = 1'b1;
    repeat (4) @(negedge clk_i);
    wr(4'h6, '0, '0, '1, '1);
    rd(4'h6);
  endtask : t_narrow
  // odd-slot command must be ignored, then a stopped clock holds the bus
  task automatic t_quiet;
    @(negedge clk_i);
    ctl_u.cmd(1'b1, 4'h3, '1, '1, '0, '0);
    repeat (11) begin
      @(negedge clk_i);
      `CHK("odd slot", 1'b0, oe)
    end
    v = dq;
    ce_i = 1'b0;
    // a command shown while stopped must leave no trace
    ctl_u.cmd(1'b1, 4'h5, '1, '1, '0, '0);
    repeat (4) @(negedge clk_i);
    `CHK("stopped", v, dq)
    ce_i = 1'b1;
    repeat (10) begin
      @(negedge clk_i);
      `CHK("frozen cmd", 1'b0, oe)
    end
    `CHK("no drop", 0, drops)
    rd(4'h5);
  endtask : t_quiet
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    t_lanes();
    t_narrow();
    t_quiet();
    final_report();
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
endmodule : ddr_burst2_cio_sram_command_timing_tb
